// ==== pkg/irq_ctrl_defines.vh ====
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define TCY_NS 160
`define PHASES_PER_TCY (`TCY_NS / `CLK_PERIOD_NS)
`define PHASE_Q1 4'h1
`define PHASE_Q4 4'h8

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CORE_CTRL 8'h00
`define OFS_PEN_A 8'h04
`define OFS_PEN_B 8'h08
`define OFS_PEN_C 8'h0C
`define OFS_PFLAG_A 8'h10
`define OFS_PFLAG_B 8'h14
`define OFS_PFLAG_C 8'h18
`define OFS_EDGE_CFG 8'h1C
`define OFS_EVT_STATUS 8'h20
`define OFS_EVT_MASK 8'h24
`define OFS_SHADOW 8'h28
`define OFS_SAVED_PC 8'h2C

// ----------------------------------------
// core_irq_control_reg fields
// ----------------------------------------
`define CC_GIE 7
`define CC_PERIPH_GROUP_IRQ_ENABLE 6
`define CC_T0_EN 5
`define CC_EXT_EN 4
`define CC_IOC_EN 3
`define CC_T0_FLAG 2
`define CC_EXT_FLAG 1
`define CC_IOC_FLAG 0

// Implemented bits of the peripheral enable and flag registers
`define PMASK_A 8'hC3
`define PMASK_B 8'h04
`define PMASK_C 8'h03

// Event status bits
`define EV_TAKEN 0
`define EV_RETURN 1
`define EV_WAKE 2
`define EV_MASK 3'h7

// ----------------------------------------
// Reset values and vector
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 32'h00000000
`define IRQ_VECTOR 15'h0004

`endif

// ==== rtl/quarter_phase_gen.v ====
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"

module quarter_phase_gen
(
  input wire clk,
  input wire rst,
  output reg [3:0] phase
);

  // ----------------------------------------
  // Rotating one-hot Q1..Q4, one core clock each
  // ----------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase <= `PHASE_Q1;
    end
    else
    begin
      phase <= {phase[2:0], phase[3]};
    end
  end

endmodule // quarter_phase_gen

// ==== rtl/ext_edge_detect.v ====
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"

module ext_edge_detect
(
  input wire clk,
  input wire rst,
  input wire pin,
  input wire polarity,
  input wire [3:0] phase,
  output reg set_pulse
);

  reg prev;
  reg held;
  wire edge_seen;
  wire set_window;
  wire pending;

  assign edge_seen = polarity ? (pin & ~prev) : (~pin & prev);
  // Flag may only rise from Q4 through the next Q1
  assign set_window = (phase == `PHASE_Q4) | (phase == `PHASE_Q1);
  assign pending = edge_seen | held;

  // Not registered: a flop here would land the flag one phase late
  always @*
  begin
    set_pulse = pending & set_window;
  end

  // ----------------------------------------
  // Edge capture, held until the set window
  // ----------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev <= 1'b0;
      held <= 1'b0;
    end
    else
    begin
      prev <= pin;
      if (pending)
      begin
        if (set_window)
        begin
          held <= 1'b0;
        end
        else
        begin
          held <= 1'b1;
        end
      end
    end
  end

endmodule // ext_edge_detect

// ==== rtl/irq_entry_exit_control.v ====
// How it works
// - Any reset leaves interrupts globally disabled
// - Redirect needs global and source enables, plus group enable for peripheral sources
// - Flags set regardless of any enable
// - Taken interrupt discards the prefetched instruction
// - Entry clears global enable, pushes PC
// - Entry copies core context into shadow
// - Entry loads PC with fixed vector
// - Disabled events stay pending until enabled
// - Return pops PC, restores context, enables
// - Synchronous latency three to four cycles
// - Asynchronous latency three to five cycles
// - Latency ignores instruction length
// - External flag sampled once per Q1
// - External flag sets only Q4 through Q1
// - Edge select chooses rising or falling
// - Sleep wake runs next instruction first
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"

module irq_entry_exit_control
(
  input wire CLK,
  input wire RST,
  input wire [7:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire [3:0] BYTEENABLE,
  output reg [31:0] READDATA,
  output reg WAITREQUEST,
  input wire EXT_PIN,
  input wire TMR0_EVT,
  input wire IOC_ANY,
  input wire [7:0] PERIPH_EVT_A,
  input wire [7:0] PERIPH_EVT_B,
  input wire [7:0] PERIPH_EVT_C,
  input wire SLEEPING,
  input wire RETURN_OP,
  input wire [14:0] PC_IN,
  input wire [31:0] CTX_IN,
  output reg FLUSH_PREFETCH,
  output reg PUSH_PC,
  output reg [14:0] PUSH_ADDR,
  output reg POP_PC,
  output reg LOAD_PC,
  output reg [14:0] LOAD_ADDR,
  output reg RESTORE_CTX,
  output reg [31:0] SHADOW_CTX,
  output reg WAKE_CORE,
  output reg GIE_OUT,
  output reg [3:0] PHASE,
  output reg IRQ
);

  // ----------------------------------------
  // Entry sequencer states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WAKE = 4'h2;
  localparam [3:0] ST_FLUSH = 4'h4;
  localparam [3:0] ST_PUSH = 4'h8;

  // Byte-lane merge for the wide shadow word
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] be;
    integer i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (be[i])
        begin
          be_merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  wire [3:0] phase;
  wire ext_set;
  wire q1;
  reg [7:0] core_irq_control_reg;
  reg [7:0] periph_enable_reg_a;
  reg [7:0] periph_enable_reg_b;
  reg [7:0] periph_enable_reg_c;
  reg [7:0] periph_flag_reg_a;
  reg [7:0] periph_flag_reg_b;
  reg [7:0] periph_flag_reg_c;
  reg ext_edge_polarity_select;
  reg [2:0] event_status;
  reg [2:0] event_mask;
  reg [14:0] saved_pc;
  reg [3:0] state;
  reg [31:0] next_readdata;
  reg [7:0] next_core;
  reg [2:0] next_status;
  wire access;
  wire wr_now;
  wire wr_lo;
  wire global_irq_enable;
  wire periph_group_irq_enable;
  wire ext_edge_irq_flag;
  wire core_req;
  wire periph_req;
  wire take;
  wire enter;
  reg [2:0] evt;

  quarter_phase_gen u_phase
  (
    .clk(CLK),
    .rst(RST),
    .phase(phase)
  );

  ext_edge_detect u_edge
  (
    .clk(CLK),
    .rst(RST),
    .pin(EXT_PIN),
    .polarity(ext_edge_polarity_select),
    .phase(phase),
    .set_pulse(ext_set)
  );

  assign q1 = (phase == `PHASE_Q1);
  assign access = READ | WRITE;
  // Write takes effect on the edge where waitrequest is seen low
  assign wr_now = WRITE & ~WAITREQUEST;
  assign wr_lo = wr_now & BYTEENABLE[0];
  assign global_irq_enable = core_irq_control_reg[`CC_GIE];
  assign periph_group_irq_enable = core_irq_control_reg[`CC_PERIPH_GROUP_IRQ_ENABLE];
  assign ext_edge_irq_flag = core_irq_control_reg[`CC_EXT_FLAG];

  // ----------------------------------------
  // Request qualification
  // ----------------------------------------
  assign core_req = (core_irq_control_reg[`CC_T0_EN] & core_irq_control_reg[`CC_T0_FLAG])
    | (core_irq_control_reg[`CC_EXT_EN] & ext_edge_irq_flag)
    | (core_irq_control_reg[`CC_IOC_EN] & core_irq_control_reg[`CC_IOC_FLAG]);
  assign periph_req = |(periph_enable_reg_a & periph_flag_reg_a)
    | |(periph_enable_reg_b & periph_flag_reg_b)
    | |(periph_enable_reg_c & periph_flag_reg_c);
  // Pending flags stay set, so a later enable services them
  assign take = global_irq_enable & (core_req | (periph_group_irq_enable & periph_req));
  // Sampled only at Q1, so instruction length never matters
  assign enter = q1 & (state == ST_IDLE) & take & ~RETURN_OP;

  // ----------------------------------------
  // Control register next value
  // ----------------------------------------
  always @*
  begin
    next_core = core_irq_control_reg;
    if (wr_lo && ADDRESS == `OFS_CORE_CTRL)
    begin
      next_core[7:1] = WRITEDATA[7:1];
    end
    // Hardware sets win over a software clear in the same cycle
    if (TMR0_EVT)
    begin
      next_core[`CC_T0_FLAG] = 1'b1;
    end
    if (ext_set)
    begin
      next_core[`CC_EXT_FLAG] = 1'b1;
    end
    next_core[`CC_IOC_FLAG] = IOC_ANY;
    if (RETURN_OP)
    begin
      next_core[`CC_GIE] = 1'b1;
    end
    if (enter)
    begin
      next_core[`CC_GIE] = 1'b0;
    end
  end

  always @*
  begin
    evt = 3'h0;
    evt[`EV_TAKEN] = enter;
    evt[`EV_RETURN] = RETURN_OP;
    evt[`EV_WAKE] = enter & SLEEPING;
    next_status = event_status;
    if (wr_lo && ADDRESS == `OFS_EVT_STATUS)
    begin
      next_status = event_status & ~WRITEDATA[2:0];
    end
    next_status = next_status | evt;
  end

  always @*
  begin
    case (ADDRESS)
      `OFS_CORE_CTRL: next_readdata = {24'h000000, core_irq_control_reg};
      `OFS_PEN_A: next_readdata = {24'h000000, periph_enable_reg_a};
      `OFS_PEN_B: next_readdata = {24'h000000, periph_enable_reg_b};
      `OFS_PEN_C: next_readdata = {24'h000000, periph_enable_reg_c};
      `OFS_PFLAG_A: next_readdata = {24'h000000, periph_flag_reg_a};
      `OFS_PFLAG_B: next_readdata = {24'h000000, periph_flag_reg_b};
      `OFS_PFLAG_C: next_readdata = {24'h000000, periph_flag_reg_c};
      `OFS_EDGE_CFG: next_readdata = {31'h0, ext_edge_polarity_select};
      `OFS_EVT_STATUS: next_readdata = {29'h0, event_status};
      `OFS_EVT_MASK: next_readdata = {29'h0, event_mask};
      `OFS_SHADOW: next_readdata = SHADOW_CTX;
      `OFS_SAVED_PC: next_readdata = {17'h0, saved_pc};
      default: next_readdata = `RST_WORD;
    endcase
  end

  // ----------------------------------------
  // Bus slave and registers
  // ----------------------------------------
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      WAITREQUEST <= 1'b1;
      READDATA <= `RST_WORD;
      core_irq_control_reg <= `RST_BYTE;
      periph_enable_reg_a <= `RST_BYTE;
      periph_enable_reg_b <= `RST_BYTE;
      periph_enable_reg_c <= `RST_BYTE;
      periph_flag_reg_a <= `RST_BYTE;
      periph_flag_reg_b <= `RST_BYTE;
      periph_flag_reg_c <= `RST_BYTE;
      ext_edge_polarity_select <= 1'b0;
      event_status <= 3'h0;
      event_mask <= 3'h0;
      IRQ <= 1'b0;
      GIE_OUT <= 1'b0;
      PHASE <= 4'h0;
    end
    else
    begin
      // One wait cycle per access, then release for one cycle
      WAITREQUEST <= ~(access & WAITREQUEST);
      if (READ & WAITREQUEST)
      begin
        READDATA <= next_readdata;
      end
      core_irq_control_reg <= next_core;
      GIE_OUT <= next_core[`CC_GIE];
      event_status <= next_status;
      IRQ <= |(next_status & event_mask);
      PHASE <= phase;
      if (wr_lo)
      begin
        case (ADDRESS)
          `OFS_PEN_A: periph_enable_reg_a <= WRITEDATA[7:0] & `PMASK_A;
          `OFS_PEN_B: periph_enable_reg_b <= WRITEDATA[7:0] & `PMASK_B;
          `OFS_PEN_C: periph_enable_reg_c <= WRITEDATA[7:0] & `PMASK_C;
          `OFS_EDGE_CFG: ext_edge_polarity_select <= WRITEDATA[0];
          `OFS_EVT_MASK: event_mask <= WRITEDATA[2:0] & `EV_MASK;
          default: ;
        endcase
      end
      // Flags: software write first, event set on top
      periph_flag_reg_a <= (((wr_lo && ADDRESS == `OFS_PFLAG_A) ? WRITEDATA[7:0]
        : periph_flag_reg_a) | PERIPH_EVT_A) & `PMASK_A;
      periph_flag_reg_b <= (((wr_lo && ADDRESS == `OFS_PFLAG_B) ? WRITEDATA[7:0]
        : periph_flag_reg_b) | PERIPH_EVT_B) & `PMASK_B;
      periph_flag_reg_c <= (((wr_lo && ADDRESS == `OFS_PFLAG_C) ? WRITEDATA[7:0]
        : periph_flag_reg_c) | PERIPH_EVT_C) & `PMASK_C;
    end
  end

  // ----------------------------------------
  // Entry and exit sequencer
  // ----------------------------------------
  // Each step is one instruction cycle, advanced at Q1. Event before
  // Q1 of cycle N: flush in N, push in N+1, vector in N+2, vector code
  // runs from N+3.
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      FLUSH_PREFETCH <= 1'b0;
      PUSH_PC <= 1'b0;
      PUSH_ADDR <= 15'h0000;
      POP_PC <= 1'b0;
      LOAD_PC <= 1'b0;
      LOAD_ADDR <= 15'h0000;
      RESTORE_CTX <= 1'b0;
      SHADOW_CTX <= `RST_WORD;
      WAKE_CORE <= 1'b0;
      saved_pc <= 15'h0000;
    end
    else
    begin
      FLUSH_PREFETCH <= 1'b0;
      PUSH_PC <= 1'b0;
      POP_PC <= 1'b0;
      LOAD_PC <= 1'b0;
      RESTORE_CTX <= 1'b0;
      WAKE_CORE <= 1'b0;
      if (wr_now && ADDRESS == `OFS_SHADOW)
      begin
        SHADOW_CTX <= be_merge(SHADOW_CTX, WRITEDATA, BYTEENABLE);
      end
      if (RETURN_OP && state == ST_IDLE)
      begin
        POP_PC <= 1'b1;
        RESTORE_CTX <= 1'b1;
      end
      if (q1)
      begin
        case (state)
          ST_IDLE:
          begin
            if (enter)
            begin
              if (SLEEPING)
              begin
                WAKE_CORE <= 1'b1;
                state <= ST_WAKE;
              end
              else
              begin
                FLUSH_PREFETCH <= 1'b1;
                state <= ST_FLUSH;
              end
            end
          end
          ST_WAKE:
          begin
            // Instruction after the sleep runs during this cycle
            FLUSH_PREFETCH <= 1'b1;
            state <= ST_FLUSH;
          end
          ST_FLUSH:
          begin
            PUSH_PC <= 1'b1;
            PUSH_ADDR <= PC_IN;
            saved_pc <= PC_IN;
            SHADOW_CTX <= CTX_IN;
            state <= ST_PUSH;
          end
          ST_PUSH:
          begin
            LOAD_PC <= 1'b1;
            LOAD_ADDR <= `IRQ_VECTOR;
            state <= ST_IDLE;
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // irq_entry_exit_control

// ==== dv/irq_entry_exit_control_assertions.sv ====
`timescale 1ns/1ps
module irq_entry_exit_control_chk
(
  input wire CLK,
  input wire RST,
  input wire READ,
  input wire WRITE,
  input wire WAITREQUEST,
  input wire RETURN_OP,
  input wire FLUSH_PREFETCH,
  input wire PUSH_PC,
  input wire POP_PC,
  input wire LOAD_PC,
  input wire [14:0] LOAD_ADDR,
  input wire RESTORE_CTX,
  input wire WAKE_CORE,
  input wire GIE_OUT,
  input wire [3:0] PHASE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // ----------
  // Entry walk
  // ----------
  sequence s_push_load;
    ##4 PUSH_PC ##4 (LOAD_PC && LOAD_ADDR == 15'h0004);
  endsequence
  property p_entry; FLUSH_PREFETCH |-> s_push_load; endproperty
  a_entry: assert property (p_entry) else $error("entry walk broken");
  property p_gate; FLUSH_PREFETCH |-> $past(GIE_OUT) || $past(WAKE_CORE, 4); endproperty
  a_gate: assert property (p_gate) else $error("entry without enable");
  property p_gie_clr; FLUSH_PREFETCH |=> !GIE_OUT; endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("enable kept on entry");
  property p_wake; WAKE_CORE |-> ##4 FLUSH_PREFETCH; endproperty
  a_wake: assert property (p_wake) else $error("wake walk broken");
  // ----------
  // Return
  // ----------
  property p_ret; POP_PC |-> RESTORE_CTX && $past(RETURN_OP) ##[0:1] GIE_OUT; endproperty
  a_ret: assert property (p_ret) else $error("return walk broken");
  // ----------
  // Reset, phases, bus
  // ----------
  property p_rst; disable iff (1'b0) RST |-> !GIE_OUT && !FLUSH_PREFETCH; endproperty
  a_rst: assert property (p_rst) else $error("enabled in reset");
  property p_q4; PHASE[3] |=> PHASE == 4'h1; endproperty
  a_q4: assert property (p_q4) else $error("phase after Q4");
  property p_q1; PHASE[0] |=> PHASE == 4'h2; endproperty
  a_q1: assert property (p_q1) else $error("phase after Q1");
  property p_wait; (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST; endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
endmodule // irq_entry_exit_control_chk

bind irq_entry_exit_control irq_entry_exit_control_chk i_chk (.CLK(CLK), .RST(RST),
  .READ(READ), .WRITE(WRITE), .WAITREQUEST(WAITREQUEST), .RETURN_OP(RETURN_OP),
  .FLUSH_PREFETCH(FLUSH_PREFETCH), .PUSH_PC(PUSH_PC), .POP_PC(POP_PC), .LOAD_PC(LOAD_PC),
  .LOAD_ADDR(LOAD_ADDR), .RESTORE_CTX(RESTORE_CTX), .WAKE_CORE(WAKE_CORE),
  .GIE_OUT(GIE_OUT), .PHASE(PHASE));

// ==== dv/core_model.sv ====
`timescale 1ns/1ps
module core_model
(
  input wire CLK,
  input wire RST,
  input wire ret_req,
  input wire LOAD_PC,
  input wire [14:0] LOAD_ADDR,
  input wire PUSH_PC,
  input wire [14:0] PUSH_ADDR,
  input wire POP_PC,
  output logic [14:0] PC_IN,
  output logic [31:0] CTX_IN,
  output logic RETURN_OP
);
  logic [14:0] stack;
  // Fixed context so the shadow copy is easy to predict
  assign CTX_IN = 32'h5A5AC3C3;
  always @(posedge CLK or posedge RST)
    if (RST)
    begin
      PC_IN <= 15'h0000;
      stack <= 15'h0000;
      RETURN_OP <= 1'b0;
    end
    else
    begin
      RETURN_OP <= ret_req;
      if (PUSH_PC)
        stack <= PUSH_ADDR;
      if (LOAD_PC)
        PC_IN <= LOAD_ADDR;
      else if (POP_PC)
        PC_IN <= stack;
      else
        PC_IN <= PC_IN + 15'h0001;
    end
endmodule // core_model

// ==== dv/irq_entry_exit_control_tb.sv ====
`timescale 1ns/1ps
module irq_entry_exit_control_tb;
  logic CLK = 1'b0;
  logic RST = 1'b0;
  logic SLEEPING = 1'b0;
  logic IOC_ANY = 1'b0;
  logic [7:0] ADDRESS = 8'h00;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0;
  logic EXT_PIN = 1'b0;
  logic TMR0_EVT = 1'b0;
  logic [7:0] PERIPH_EVT_A = 8'h00;
  logic ret_req = 1'b0;
  wire [31:0] READDATA, SHADOW_CTX, CTX_IN;
  wire [14:0] PC_IN, PUSH_ADDR, LOAD_ADDR;
  wire [3:0] PHASE;
  wire WAITREQUEST, RETURN_OP, FLUSH_PREFETCH, PUSH_PC, POP_PC, LOAD_PC, GIE_OUT, IRQ;
  wire WAKE_CORE;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer loads = 0;
  integer wakes = 0;
  integer n;
  logic [31:0] q;
  always #20 CLK = ~CLK;
  always @(posedge CLK)
  begin
    if (LOAD_PC === 1'b1)
      loads <= loads + 1;
    if (WAKE_CORE === 1'b1)
      wakes <= wakes + 1;
  end
  irq_entry_exit_control i_irq_entry_exit_control (.CLK(CLK), .RST(RST), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(4'hF),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .EXT_PIN(EXT_PIN), .TMR0_EVT(TMR0_EVT),
    .IOC_ANY(IOC_ANY), .PERIPH_EVT_A(PERIPH_EVT_A), .PERIPH_EVT_B(8'h00),
    .PERIPH_EVT_C(8'h00), .SLEEPING(SLEEPING), .RETURN_OP(RETURN_OP), .PC_IN(PC_IN),
    .CTX_IN(CTX_IN), .FLUSH_PREFETCH(FLUSH_PREFETCH), .PUSH_PC(PUSH_PC),
    .PUSH_ADDR(PUSH_ADDR), .POP_PC(POP_PC), .LOAD_PC(LOAD_PC), .LOAD_ADDR(LOAD_ADDR),
    .RESTORE_CTX(), .SHADOW_CTX(SHADOW_CTX), .WAKE_CORE(WAKE_CORE), .GIE_OUT(GIE_OUT),
    .PHASE(PHASE), .IRQ(IRQ));
  core_model i_core_model (.CLK(CLK), .RST(RST), .ret_req(ret_req), .LOAD_PC(LOAD_PC),
    .LOAD_ADDR(LOAD_ADDR), .PUSH_PC(PUSH_PC), .PUSH_ADDR(PUSH_ADDR), .POP_PC(POP_PC),
    .PC_IN(PC_IN), .CTX_IN(CTX_IN), .RETURN_OP(RETURN_OP));
  // ----------
  // Helpers
  // ----------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input string what);
    chk(what, 32'h1, 32'h0);
    end_of_test;
  endtask
  task automatic tick(input integer k);
    repeat (k) @(posedge CLK);
  endtask
  // Request held until waitrequest is sampled low; a spare edge keeps strobes clean
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    ADDRESS <= a;
    WRITEDATA <= d;
    READ <= ~wr;
    WRITE <= wr;
    do
    begin
      @(posedge CLK);
      k++;
    end
    while (WAITREQUEST !== 1'b0 && k < 20);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    if (k >= 20)
      hang("bus");
    @(posedge CLK);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask
  task automatic wait_for(input logic pop);
    n = 0;
    while ((pop ? POP_PC : LOAD_PC) !== 1'b1 && n < 40)
    begin
      @(posedge CLK);
      n++;
    end
    if (n >= 40)
      hang("core pulse");
  endtask
  task automatic pulse(input logic [8:0] v);
    {TMR0_EVT, PERIPH_EVT_A} <= v;
    @(posedge CLK);
    {TMR0_EVT, PERIPH_EVT_A} <= 9'h000;
  endtask
  task automatic do_return;
    ret_req <= 1'b1;
    @(posedge CLK);
    ret_req <= 1'b0;
    wait_for(1'b1);
    tick(2);
    chk("gie_out", 32'h1, GIE_OUT);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    chk("gie_out", 32'h0, GIE_OUT);
    rchk("ctrl", 8'h00, 32'h00);
    rchk("unmapped", 8'h30, 32'h00);
    $display("t_reset done");
  endtask
  task automatic t_pending;
    pulse(9'h1FF);
    tick(8);
    chk("loads", 32'h0, loads);
    rchk("ctrl", 8'h00, 32'h04);
    rchk("flag_a", 8'h10, 32'hC3);
    bus(1'b1, 8'h00, 32'hA4);
    wait_for(1'b0);
    chk("vector", 32'h4, {17'h0, LOAD_ADDR});
    chk("shadow", 32'h5A5AC3C3, SHADOW_CTX);
    tick(2);
    chk("gie_out", 32'h0, GIE_OUT);
    bus(1'b1, 8'h00, 32'h20);
    do_return;
    $display("t_pending done");
  endtask
  task automatic t_group;
    bus(1'b1, 8'h04, 32'h01);
    bus(1'b1, 8'h10, 32'h00);
    bus(1'b1, 8'h00, 32'h80);
    pulse(9'h001);
    tick(24);
    chk("loads", 32'h1, loads);
    bus(1'b1, 8'h00, 32'hC0);
    wait_for(1'b0);
    bus(1'b1, 8'h10, 32'h00);
    do_return;
    $display("t_group done");
  endtask
  task automatic t_ext;
    for (int p = 1; p >= 0; p--)
    begin
      bus(1'b1, 8'h1C, p);
      bus(1'b1, 8'h00, 32'h10);
      bus(1'b1, 8'h00, 32'h90);
      EXT_PIN <= p[0];
      wait_for(1'b0);
      chk("latency", 32'h1, (n >= 10 && n <= 18));
      rchk("ctrl", 8'h00, 32'h12);
      bus(1'b1, 8'h00, 32'h10);
      do_return;
    end
    $display("t_ext done");
  endtask
  task automatic t_irq;
    rchk("status", 8'h20, 32'h3);
    chk("irq", 32'h0, IRQ);
    bus(1'b1, 8'h24, 32'h7);
    tick(1);
    chk("irq", 32'h1, IRQ);
    bus(1'b1, 8'h20, 32'h7);
    tick(1);
    chk("irq", 32'h0, IRQ);
    $display("t_irq done");
  endtask
  // Change source asleep: wake pulse, then entry one cycle later
  task automatic t_sleep;
    SLEEPING <= 1'b1;
    IOC_ANY <= 1'b1;
    bus(1'b1, 8'h00, 32'h88);
    wait_for(1'b0);
    chk("wakes", 32'h1, wakes);
    rchk("status", 8'h20, 32'h5);
    chk("irq", 32'h1, IRQ);
    chk("gie_out", 32'h0, GIE_OUT);
    IOC_ANY <= 1'b0;
    SLEEPING <= 1'b0;
    bus(1'b1, 8'h00, 32'h08);
    do_return;
    $display("t_sleep done");
  endtask
  initial
  begin
    RST <= 1'b1;
    tick(2);
    RST <= 1'b0;
    @(posedge CLK);
    t_reset;
    t_pending;
    t_group;
    t_ext;
    t_irq;
    t_sleep;
    bus(1'b1, 8'h00, 32'h80);
    RST <= 1'b1;
    tick(2);
    RST <= 1'b0;
    @(posedge CLK);
    t_reset;
    end_of_test;
  end
endmodule // irq_entry_exit_control_tb
